// file: logic/port_ctl_pkg.sv
/*
  Package: offsets, field positions, reset values and test selector codes
  for the root port control and status block.
  Assumes a 32-bit AHB-Lite register bus, one aligned word per register.
*/
package port_ctl_pkg;
  localparam int NumPorts = 2;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OffPortStatusCtl0 = 8'h64;
  localparam logic [7:0] OffPortStatusCtl1 = 8'h68;
  localparam logic [7:0] OffConfigureFlag = 8'h40;
  localparam logic [7:0] OffStructParams = 8'h04;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PosTestSelLo = 16;
  localparam int PosOwner = 13;
  localparam int PosPower = 12;
  localparam int PosLineDp = 11;
  localparam int PosLineDm = 10;
  localparam int PosEnabled = 2;
  localparam int PosConnect = 0;
  localparam int PosConfigured = 0;
  localparam int PosPowerCap = 4;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RstOwner = 1'b1;
  localparam logic RstPower = 1'b0;
  localparam logic [3:0] RstTestSel = 4'h0;
  localparam logic RstConfigured = 1'b0;
  // ----------------------------------------------------------------
  // Test selector codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TmNormal, TmJState, TmKState, TmSe0Nak, TmPacket, TmForceEnable, TmReserved
  } test_mode_t;
  localparam logic [3:0] TsNormal = 4'h0;
  localparam logic [3:0] TsJState = 4'h1;
  localparam logic [3:0] TsKState = 4'h2;
  localparam logic [3:0] TsSe0Nak = 4'h3;
  localparam logic [3:0] TsPacket = 4'h4;
  localparam logic [3:0] TsForceEnable = 4'h5;
endpackage

// file: logic/port_owner_power_ctl.sv
/*
  Root port ownership, power and line state control with AHB-Lite slave.
  Assumes single-word transfers; line and overcurrent pins are asynchronous.
*/
`timescale 1ns/1ps
module port_owner_power_ctl
  import port_ctl_pkg::*;
#(
  parameter logic PowerCapDefault = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [NumPorts-1:0] lineDpPin,
  input wire logic [NumPorts-1:0] lineDmPin,
  input wire logic [NumPorts-1:0] overCurrentPin,
  input wire logic [NumPorts-1:0] connected,
  input wire logic [NumPorts-1:0] portEnabled,
  output logic [NumPorts-1:0] companionOwns,
  output logic [NumPorts-1:0] powerSwitchOn,
  output logic [4*NumPorts-1:0] testSelect
);
  import port_ctl_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic configured;
    logic powerCap;
    logic wrPending;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic [NumPorts-1:0] dpMeta, dpSync, dmMeta, dmSync, ocMeta, ocSync;
    logic [NumPorts-1:0] ownOut, powOut;
    logic [4*NumPorts-1:0] tsOut;
  } top_state_t;
  top_state_t state_reg, state_next;

  logic [NumPorts-1:0] owner, power;
  logic [3:0] testSel [NumPorts];
  logic [31:0] statusWord [NumPorts];
  logic configuredRise;
  logic [NumPorts-1:0] portWr;
  logic addrPhase;

  assign addrPhase = hsel && hready && htrans[1];

  // ----------------------------------------------------------------
  // Per-port slices
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NumPorts; g++) begin : gPort
      root_port_slice slice (
        .clk(clk),
        .rst(rst),
        .powerCap(state_reg.powerCap),
        .configured(state_reg.configured),
        .configuredRise(configuredRise),
        .wrEn(portWr[g]),
        .wrData(hwdata),
        .overCurrent(state_reg.ocSync[g]),
        .lineDp(state_reg.dpSync[g]),
        .lineDm(state_reg.dmSync[g]),
        .connected(connected[g]),
        .portEnabled(portEnabled[g]),
        .owner(owner[g]),
        .power(power[g]),
        .testSel(testSel[g]),
        .testMode(),
        .statusWord(statusWord[g])
      );
    end
  endgenerate

  always_comb begin
    portWr = '0;
    configuredRise = 1'b0;
    if (state_reg.wrPending) begin
      portWr[0] = (state_reg.addr == OffPortStatusCtl0);
      portWr[1] = (state_reg.addr == OffPortStatusCtl1);
      configuredRise = (state_reg.addr == OffConfigureFlag) &&
                       hwdata[PosConfigured] && !state_reg.configured;
    end
  end

  // ----------------------------------------------------------------
  // Bus and synchronisers
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.dpMeta = lineDpPin;
    state_next.dpSync = state_reg.dpMeta;
    state_next.dmMeta = lineDmPin;
    state_next.dmSync = state_reg.dmMeta;
    state_next.ocMeta = overCurrentPin;
    state_next.ocSync = state_reg.ocMeta;
    state_next.ownOut = owner;
    state_next.powOut = power;
    for (int i = 0; i < NumPorts; i++) begin
      state_next.tsOut[4*i +: 4] = testSel[i];
    end
    state_next.wrPending = 1'b0;
    if (state_reg.wrPending && state_reg.addr == OffConfigureFlag) begin
      state_next.configured = hwdata[PosConfigured];
    end else if (state_reg.wrPending && state_reg.addr == OffStructParams) begin
      state_next.powerCap = hwdata[PosPowerCap];
    end
    if (addrPhase) begin
      state_next.addr = haddr[7:0];
      state_next.wrPending = hwrite;
      // Read data captured at address phase; zero for unmapped offsets
      case (haddr[7:0])
        OffPortStatusCtl0: state_next.rdata = statusWord[0];
        OffPortStatusCtl1: state_next.rdata = statusWord[1];
        OffConfigureFlag: state_next.rdata = {31'h0, state_reg.configured};
        OffStructParams: state_next.rdata = 32'(state_reg.powerCap) << PosPowerCap;
        default: state_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.configured <= RstConfigured;
      state_reg.powerCap <= PowerCapDefault;
      state_reg.ownOut <= '1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign hrdata = state_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign companionOwns = state_reg.ownOut;
  assign powerSwitchOn = state_reg.powOut;
  assign testSelect = state_reg.tsOut;
endmodule

// file: logic/root_port_slice.sv
/*
  One root port: ownership, power switch, test selector, line state.
  Assumes line inputs already synchronised and writes pre-decoded.
*/
`timescale 1ns/1ps
module root_port_slice
  import port_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic powerCap,
  input wire logic configured,
  input wire logic configuredRise,
  input wire logic wrEn,
  input wire logic [31:0] wrData,
  input wire logic overCurrent,
  input wire logic lineDp,
  input wire logic lineDm,
  input wire logic connected,
  input wire logic portEnabled,
  output logic owner,
  output logic power,
  output logic [3:0] testSel,
  output test_mode_t testMode,
  output logic [31:0] statusWord
);
  typedef struct packed {
    logic owner;
    logic power;
    logic [3:0] testSel;
    test_mode_t testMode;
    logic [1:0] line;
  } slice_state_t;
  slice_state_t state_reg, state_next;

  always_comb begin
    state_next = state_reg;
    if (wrEn) begin
      state_next.owner = wrData[PosOwner];
      state_next.power = wrData[PosPower];
      state_next.testSel = wrData[PosTestSelLo +: 4];
    end
    if (powerCap && state_reg.power && overCurrent) begin
      state_next.power = 1'b0;
    end
    if (!powerCap) begin
      state_next.power = 1'b1;
    end
    if (configuredRise) begin
      state_next.owner = 1'b0;
    end else if (!configured) begin
      state_next.owner = 1'b1;
    end
    case (state_next.testSel)
      TsNormal: state_next.testMode = TmNormal;
      TsJState: state_next.testMode = TmJState;
      TsKState: state_next.testMode = TmKState;
      TsSe0Nak: state_next.testMode = TmSe0Nak;
      TsPacket: state_next.testMode = TmPacket;
      TsForceEnable: state_next.testMode = TmForceEnable;
      default: state_next.testMode = TmReserved;
    endcase
    // Line bits only meaningful when powered, disabled and connected; zero otherwise
    if (state_reg.power && !portEnabled && connected) begin
      state_next.line = {lineDp, lineDm};
    end else begin
      state_next.line = 2'b00;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '{owner: RstOwner, power: RstPower, testSel: RstTestSel,
                     testMode: TmNormal, line: 2'b00};
    end else begin
      state_reg <= state_next;
    end
  end

  assign owner = state_reg.owner;
  assign power = state_reg.power;
  assign testSel = state_reg.testSel;
  assign testMode = state_reg.testMode;

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[PosTestSelLo +: 4] = state_reg.testSel;
    statusWord[PosOwner] = state_reg.owner;
    statusWord[PosPower] = state_reg.power;
    // Unpowered port reports nothing else
    if (state_reg.power) begin
      statusWord[PosLineDp] = state_reg.line[1];
      statusWord[PosLineDm] = state_reg.line[0];
      statusWord[PosEnabled] = portEnabled;
      statusWord[PosConnect] = connected;
    end
  end
endmodule

// file: verification/port_owner_power_ctl_checker.sv
/* Checker for the root port control block.
   Sees only the top module's ports; bound at the foot of this file. */
`timescale 1ns/1ps
module port_owner_power_ctl_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [1:0] companionOwns,
  input wire logic [7:0] testSelect
);
  // ------
  // Shadow of bus writes
  // ------
  logic take, wrPh, cfg;
  logic [7:0] adr;
  assign take = hsel && hready && htrans[1];
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPh <= 1'b0;
      cfg <= 1'b0;
      adr <= 8'h00;
    end else begin
      wrPh <= take && hwrite;
      if (take) adr <= haddr[7:0];
      if (wrPh && adr == 8'h40) cfg <= hwdata[0];
    end
  end
  // ------
  // Properties
  // ------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Flag outputs lag a write data phase by two or three edges
  sequence wrSeq;
    $past(wrPh) || $past(wrPh, 2) || $past(wrPh, 3);
  endsequence
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  chk_reset_vals: assert property (
    $fell(rst) |-> companionOwns == 2'h3 && testSelect == 8'h00 && hrdata == 32'h0)
    else $error("wrong values after reset");
  chk_read_hold: assert property (!take |=> $stable(hrdata))
    else $error("read data moved without a transfer");
  chk_unmapped_zero: assert property (take && !hwrite &&
    !(haddr[7:0] inside {8'h04, 8'h40, 8'h64, 8'h68}) |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_owner_held: assert property ((!cfg) [*4] |-> companionOwns == 2'h3)
    else $error("owner not held while unconfigured");
  chk_owner_cleared: assert property ($rose(cfg) |-> ##[1:3] companionOwns == 2'h0)
    else $error("owner not cleared on configure");
  chk_owner_cause: assert property (
    $changed(companionOwns) && !$past(rst) |-> wrSeq)
    else $error("owner moved without a write");
  chk_sel_stable: assert property ((!wrPh) [*4] |=> $stable(testSelect))
    else $error("selector moved without a write");
endmodule

bind port_owner_power_ctl port_owner_power_ctl_checker chk_u (.clk, .rst, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .companionOwns,
  .testSelect);

// file: verification/tb_hs_port_owner_power_linestate.sv
/* Testbench for the root port control block.
   Assumes the checker is bound and one device model per port. */
`timescale 1ns/1ps
module tb_hs_port_owner_power_linestate;
  import port_ctl_pkg::*;
  // ------
  // Stimulus and wiring
  // ------
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0, ovc = 2'h0, pEn = 2'h0, own, pwr;
  // Per-bit drivers from two device models, so nets rather than variables
  wire [1:0] dp, dm, conn;
  logic [3:0] kind = 4'h0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] tsel;
  int fails = 0, num_checks = 0, cyc = 0;
  initial forever #10 clk = ~clk;
  port_owner_power_ctl dut_u (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .lineDpPin(dp), .lineDmPin(dm),
    .overCurrentPin(ovc), .connected(conn), .portEnabled(pEn), .companionOwns(own),
    .powerSwitchOn(pwr), .testSelect(tsel));
  usb_dev_model dev_u0 (.power(pwr[0]), .kind(kind[1:0]), .dp(dp[0]), .dm(dm[0]),
    .conn(conn[0]));
  usb_dev_model dev_u1 (.power(pwr[1]), .kind(kind[3:2]), .dp(dp[1]), .dm(dm[1]),
    .conn(conn[1]));
  // ------
  // Shared tasks
  // ------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Holds each phase until hready is seen high; the timeout bounds the wait
  task automatic xfer(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Covers two sync stages, the slice and the output register
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_reset();
    xfer(1'b0, OffPortStatusCtl0, 32'h0);
    cmp("status0", 32'h2000, rd);
    cmp("owners", 32'h3, {30'h0, own});
    cmp("power", 32'h0, {30'h0, pwr});
  endtask
  task automatic t_owner();
    xfer(1'b1, OffPortStatusCtl0, 32'h0);
    settle();
    cmp("owner held", 32'h3, {30'h0, own});
    xfer(1'b1, OffConfigureFlag, 32'h1);
    settle();
    cmp("owner cleared", 32'h0, {30'h0, own});
    xfer(1'b1, OffPortStatusCtl1, 32'h2000);
    settle();
    cmp("handoff", 32'h2, {30'h0, own});
    xfer(1'b1, OffConfigureFlag, 32'h0);
    settle();
    cmp("owner forced", 32'h3, {30'h0, own});
  endtask
  task automatic t_power();
    xfer(1'b1, OffStructParams, 32'h0);
    settle();
    cmp("no switch", 32'h3, {30'h0, pwr});
    xfer(1'b1, OffStructParams, 32'h10);
    xfer(1'b1, OffPortStatusCtl0, 32'h1000);
    xfer(1'b1, OffPortStatusCtl1, 32'h0);
    settle();
    cmp("switch", 32'h1, {30'h0, pwr});
    ovc <= 2'h1;
    settle();
    cmp("overcurrent", 32'h0, {30'h0, pwr});
    ovc <= 2'h0;
  endtask
  task automatic t_line();
    xfer(1'b1, OffConfigureFlag, 32'h1);
    xfer(1'b1, OffPortStatusCtl0, 32'h1000);
    kind <= 4'h6;
    settle();
    xfer(1'b0, OffPortStatusCtl0, 32'h0);
    cmp("kstate", 32'h1401, rd);
    xfer(1'b1, OffPortStatusCtl0, 32'h3000);
    settle();
    cmp("low speed owner", 32'h1, {30'h0, own});
    xfer(1'b0, OffPortStatusCtl1, 32'h0);
    cmp("unpowered", 32'h0, rd);
    kind <= 4'h1;
    pEn <= 2'h1;
    settle();
    xfer(1'b0, OffPortStatusCtl0, 32'h0);
    cmp("enabled", 32'h3005, rd);
    pEn <= 2'h0;
    settle();
    xfer(1'b0, OffPortStatusCtl0, 32'h0);
    cmp("jstate", 32'h3801, rd);
    kind <= 4'h3;
    settle();
    xfer(1'b0, OffPortStatusCtl0, 32'h0);
    cmp("se0", 32'h3001, rd);
    xfer(1'b0, 8'h80, 32'h0);
    cmp("unmapped", 32'h0, rd);
  endtask
  task automatic t_test();
    // Reserved codes included: the selector must still store them
    for (int c = 0; c < 16; c++) begin
      xfer(1'b1, OffPortStatusCtl1, {12'h0, 4'(c), 16'h0});
      settle();
      cmp("selector", {24'h0, 4'(c), 4'h0}, {24'h0, tsel});
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_owner();
    t_power();
    t_line();
    t_test();
    wrap_up();
  end
endmodule

// file: verification/usb_dev_model.sv
/* Partner: device attached to one root port.
   Assumes host pull-downs, so released lines read low. */
`timescale 1ns/1ps
module usb_dev_model (
  input wire logic power,
  input wire logic [1:0] kind,
  output logic dp,
  output logic dm,
  output logic conn
);
  // Kind 0 absent, 1 full speed (J idle), 2 low speed (K idle), 3 connected at SE0
  assign conn = power && kind != 2'h0;
  assign dp = power && kind == 2'h1;
  assign dm = power && kind == 2'h2;
endmodule
